/* File: src/prcis_pkg.sv */
// How it works
// - After reset only DMA/transfer and RAM run; every other module is stopped.
// - DMA/transfer stop bit resets to 0; writing 1 stops that module.
// - RAM stop bit resets to running; setting it stops the RAM.
// - A stopped module has its functions halted to save power.
// - Each source's stable flag reads 1 once its oscillator has settled.
package prcis_pkg;
	localparam logic [7:0] ADDR_MSTP_A   = 8'h00;
	localparam logic [7:0] ADDR_MSTP_C   = 8'h04;
	localparam logic [7:0] ADDR_MSTP_X   = 8'h08;
	localparam logic [7:0] ADDR_SUB_WAIT = 8'h0C;
	localparam logic [7:0] ADDR_MAIN_WAIT= 8'h10;
	localparam logic [7:0] ADDR_OSC_CTRL = 8'h14;
	localparam logic [7:0] ADDR_PLL_CTRL = 8'h18;
	localparam logic [7:0] ADDR_DIV_CTRL = 8'h1C;
	localparam logic [7:0] ADDR_SYS_SEL  = 8'h20;
	localparam logic [7:0] ADDR_STABLE   = 8'h24;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h28;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h2C;
	localparam int DMA_STOP_POS = 28;
	localparam int RAM_STOP_POS = 0;
	localparam logic [31:0] MSTP_A_RST = 32'h0000_0000;
	localparam logic [31:0] MSTP_C_RST = 32'h0000_0000;
	localparam logic [31:0] MSTP_X_RST = 32'hFFFF_FFFF;
	// Oscillator control bit positions
	localparam int OSC_SUB  = 0;
	localparam int OSC_MAIN = 1;
	localparam int OSC_FAST = 2;
	localparam int OSC_PLL  = 3;
	localparam int FAST_PWR = 4;
	localparam int PLL_PWR  = 5;
	localparam int SUB_INIT = 6;
	localparam logic [3:0] SRC_FAST = 4'h1;
	localparam logic [3:0] SRC_MAIN = 4'h2;
	localparam logic [3:0] SRC_SUB  = 4'h3;
	localparam logic [3:0] SRC_PLL  = 4'h4;
	localparam logic [3:0] SYS_SEL_RST = SRC_FAST;
	localparam logic [31:0] DIV_RST = 32'h0000_0000;
	// Irq bits: sub, main, fast, pll stable; switch done; switch refused
	localparam int IRQ_SWOK  = 4;
	localparam int IRQ_SWBAD = 5;
	// Settle counts, cycles at 10 MHz (period 100 ns)
	localparam int CLK_NS    = 100;
	localparam int SETTLE_US = 10;
	localparam int SETTLE_CYC = (SETTLE_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam logic [15:0] SETTLE_RST = 16'(SETTLE_CYC);
	typedef enum logic [2:0] {
		OS_OFF    = 3'b001,
		OS_RAMP   = 3'b010,
		OS_STABLE = 3'b100
	} prcis_osc_type;
endpackage

/* File: src/prcis_osc_model.sv */
`timescale 1ns/1ps
// One oscillator's settling tracker: stable flag after enable + wait count
module prcis_osc_model
	import prcis_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        run,
	input  wire logic [15:0] wait_cyc,
	output logic             stable
);
	typedef struct packed {
		prcis_osc_type st;
		logic [15:0]   cnt;
		logic          stable;
	} prcis_om_type;
	prcis_om_type s_r;
	prcis_om_type s_nxt;
	always_comb
	begin
		s_nxt = s_r;
		case (s_r.st)
			OS_OFF:
			begin
				s_nxt.cnt = wait_cyc;
				if (run)
					s_nxt.st = OS_RAMP;
			end
			OS_RAMP:
			begin
				if (!run)
					s_nxt.st = OS_OFF;
				else if (s_r.cnt <= 16'h0001)
				begin
					s_nxt.st = OS_STABLE;
					s_nxt.stable = 1'b1;
				end
				else
					s_nxt.cnt = s_r.cnt - 16'h0001;
			end
			OS_STABLE:
			begin
				if (!run)
				begin
					s_nxt.st = OS_OFF;
					s_nxt.stable = 1'b0;
				end
			end
			default:
				s_nxt.st = OS_OFF;
		endcase
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_r.st <= OS_OFF;
			s_r.cnt <= 16'h0000;
			s_r.stable <= 1'b0;
		end
		else
			s_r <= s_nxt;
	end
	assign stable = s_r.stable;
endmodule // prcis_osc_model

/* File: src/prcis_top.sv */
`timescale 1ns/1ps
module prcis_top
	import prcis_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             dma_run,
	output logic             ram_run,
	output logic [31:0]      periph_run,
	output logic [3:0]       sys_clk_src,
	output logic [31:0]      clk_div,
	output logic             irq
);
	typedef struct packed {
		logic        aw_ok;
		logic [7:0]  awa;
		logic        w_ok;
		logic [31:0] wd;
		logic [3:0]  ws;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [31:0] mstp_a;
		logic [31:0] mstp_c;
		logic [31:0] mstp_x;
		logic [15:0] sub_wait;
		logic [15:0] main_wait;
		logic [6:0]  osc;
		logic [31:0] pll;
		logic [31:0] div;
		logic [3:0]  sel;
		logic [5:0]  ist;
		logic [5:0]  imask;
		logic [3:0]  stab_d;
		logic        irq;
	} prcis_top_type;
	prcis_top_type s_r;
	prcis_top_type s_nxt;
	logic [3:0] stab;
	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (st[i])
				r[i*8 +: 8] = d[i*8 +: 8];
		return r;
	endfunction
	function automatic logic src_ok(input logic [3:0] src,
		input logic [3:0] f);
		case (src)
			SRC_SUB:  src_ok = f[OSC_SUB];
			SRC_MAIN: src_ok = f[OSC_MAIN];
			SRC_FAST: src_ok = f[OSC_FAST];
			SRC_PLL:  src_ok = f[OSC_PLL];
			default:  src_ok = 1'b0;
		endcase
	endfunction
	// Sub circuit runs only after its init bit; fast/PLL gated by power
	prcis_osc_model u_sub (.aclk(aclk), .aresetn(aresetn),
		.run(s_r.osc[OSC_SUB] & s_r.osc[SUB_INIT]),
		.wait_cyc(s_r.sub_wait), .stable(stab[0]));
	prcis_osc_model u_main (.aclk(aclk), .aresetn(aresetn),
		.run(s_r.osc[OSC_MAIN]),
		.wait_cyc(s_r.main_wait), .stable(stab[1]));
	prcis_osc_model u_fast (.aclk(aclk), .aresetn(aresetn),
		.run(s_r.osc[OSC_FAST] & s_r.osc[FAST_PWR]),
		.wait_cyc(SETTLE_RST), .stable(stab[2]));
	prcis_osc_model u_pll (.aclk(aclk), .aresetn(aresetn),
		.run(s_r.osc[OSC_PLL] & s_r.osc[PLL_PWR]
			& src_ok(s_r.pll[3:0], stab)),
		.wait_cyc(SETTLE_RST), .stable(stab[3]));
	always_comb
	begin
		logic [31:0] wv;
		logic [5:0]  ev;
		logic        wr;
		logic [3:0]  want;
		wv = 32'h0000_0000;
		ev = {2'b00, stab & ~s_r.stab_d};
		want = 4'h0;
		s_nxt = s_r;
		s_nxt.stab_d = stab;
		if (s_axi_awvalid && !s_r.aw_ok && !s_r.bvalid)
		begin
			s_nxt.aw_ok = 1'b1;
			s_nxt.awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_r.w_ok && !s_r.bvalid)
		begin
			s_nxt.w_ok = 1'b1;
			s_nxt.wd = s_axi_wdata;
			s_nxt.ws = s_axi_wstrb;
		end
		wr = s_r.aw_ok && s_r.w_ok;
		if (wr)
		begin
			s_nxt.aw_ok = 1'b0;
			s_nxt.w_ok = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = 2'b00;
			case (s_r.awa)
				ADDR_MSTP_A:
					s_nxt.mstp_a = wmerge(s_r.mstp_a, s_r.wd, s_r.ws);
				ADDR_MSTP_C:
					s_nxt.mstp_c = wmerge(s_r.mstp_c, s_r.wd, s_r.ws);
				ADDR_MSTP_X:
					s_nxt.mstp_x = wmerge(s_r.mstp_x, s_r.wd, s_r.ws);
				ADDR_SUB_WAIT:
				begin
					wv = wmerge({16'h0000, s_r.sub_wait}, s_r.wd, s_r.ws);
					s_nxt.sub_wait = wv[15:0];
				end
				ADDR_MAIN_WAIT:
				begin
					wv = wmerge({16'h0000, s_r.main_wait}, s_r.wd, s_r.ws);
					s_nxt.main_wait = wv[15:0];
				end
				ADDR_OSC_CTRL:
				begin
					wv = wmerge({25'h0, s_r.osc}, s_r.wd, s_r.ws);
					s_nxt.osc = wv[6:0];
				end
				ADDR_PLL_CTRL:
					s_nxt.pll = wmerge(s_r.pll, s_r.wd, s_r.ws);
				ADDR_DIV_CTRL:
					s_nxt.div = wmerge(s_r.div, s_r.wd, s_r.ws);
				ADDR_SYS_SEL:
				begin
					want = s_r.wd[3:0];
					if (s_r.ws[0] && src_ok(want, stab))
					begin
						s_nxt.sel = want;
						ev[IRQ_SWOK] = 1'b1;
					end
					else if (s_r.ws[0])
					begin
						ev[IRQ_SWBAD] = 1'b1;
						s_nxt.bresp = 2'b10;
					end
				end
				ADDR_IRQ_STAT:
					s_nxt.ist = s_r.ist & ~s_r.wd[5:0];
				ADDR_IRQ_MASK:
					s_nxt.imask = s_r.wd[5:0];
				ADDR_STABLE:
					s_nxt.bresp = 2'b00;
				default:
					s_nxt.bresp = 2'b10;
			endcase
		end
		if (s_r.bvalid && s_axi_bready)
			s_nxt.bvalid = 1'b0;
		// Set wins over a write-one clear in the same cycle
		s_nxt.ist = s_nxt.ist | ev;
		if (s_axi_arvalid && !s_r.rvalid)
		begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = 2'b00;
			case (s_axi_araddr)
				ADDR_MSTP_A:    s_nxt.rdata = s_r.mstp_a;
				ADDR_MSTP_C:    s_nxt.rdata = s_r.mstp_c;
				ADDR_MSTP_X:    s_nxt.rdata = s_r.mstp_x;
				ADDR_SUB_WAIT:  s_nxt.rdata = {16'h0000, s_r.sub_wait};
				ADDR_MAIN_WAIT: s_nxt.rdata = {16'h0000, s_r.main_wait};
				ADDR_OSC_CTRL:  s_nxt.rdata = {25'h0, s_r.osc};
				ADDR_PLL_CTRL:  s_nxt.rdata = s_r.pll;
				ADDR_DIV_CTRL:  s_nxt.rdata = s_r.div;
				ADDR_SYS_SEL:   s_nxt.rdata = {28'h0, s_r.sel};
				ADDR_STABLE:    s_nxt.rdata = {28'h0, stab};
				ADDR_IRQ_STAT:  s_nxt.rdata = {26'h0, s_r.ist};
				ADDR_IRQ_MASK:  s_nxt.rdata = {26'h0, s_r.imask};
				default:
				begin
					s_nxt.rdata = 32'h0000_0000;
					s_nxt.rresp = 2'b10;
				end
			endcase
		end
		else if (s_r.rvalid && s_axi_rready)
			s_nxt.rvalid = 1'b0;
		s_nxt.irq = |(s_nxt.ist & s_nxt.imask);
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_r <= '0;
			s_r.mstp_a <= MSTP_A_RST;
			s_r.mstp_c <= MSTP_C_RST;
			s_r.mstp_x <= MSTP_X_RST;
			s_r.sub_wait <= SETTLE_RST;
			s_r.main_wait <= SETTLE_RST;
			s_r.div <= DIV_RST;
			s_r.sel <= SYS_SEL_RST;
			s_r.osc <= 7'h34;
		end
		else
			s_r <= s_nxt;
	end
	assign s_axi_awready = s_axi_awvalid & ~s_r.aw_ok & ~s_r.bvalid;
	assign s_axi_wready  = s_axi_wvalid & ~s_r.w_ok & ~s_r.bvalid;
	assign s_axi_bvalid  = s_r.bvalid;
	assign s_axi_bresp   = s_r.bresp;
	assign s_axi_arready = s_axi_arvalid & ~s_r.rvalid;
	assign s_axi_rvalid  = s_r.rvalid;
	assign s_axi_rdata   = s_r.rdata;
	assign s_axi_rresp   = s_r.rresp;
	// Stop bits halt the module's run enable, the power saving itself
	assign dma_run     = ~s_r.mstp_a[DMA_STOP_POS];
	assign ram_run     = ~s_r.mstp_c[RAM_STOP_POS];
	assign periph_run  = ~s_r.mstp_x;
	assign sys_clk_src = s_r.sel;
	assign clk_div     = s_r.div;
	assign irq         = s_r.irq;
endmodule // prcis_top

/* File: test/prcis_asserts.sv */
`timescale 1ns/1ps
module prcis_asserts (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        dma_run,
	input wire logic        ram_run,
	input wire logic [31:0] periph_run,
	input wire logic [3:0]  sys_clk_src
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	rst_state_a: assert property (
		disable iff (1'b0) !aresetn |=>
		dma_run && ram_run && periph_run == 32'h0000_0000)
		else $error("run outputs wrong after reset");
	dma_stop_a: assert property (
		$changed(dma_run) |-> ##[0:1] s_axi_bvalid)
		else $error("dma run changed without a write");
	ram_stop_a: assert property (
		$changed(ram_run) |-> ##[0:1] s_axi_bvalid)
		else $error("ram run changed without a write");
	sel_guard_a: assert property (
		$changed(sys_clk_src) |->
		##[0:1] (s_axi_bvalid && s_axi_bresp == 2'h0))
		else $error("clock source changed without accepted write");
	wr_answer_a: assert property (wr_taken |=> ##1 s_axi_bvalid)
		else $error("write response late");
	rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read data late");
	b_release_a: assert property (s_axi_bvalid && s_axi_bready |=>
		!s_axi_bvalid)
		else $error("write response not released");
	r_release_a: assert property (s_axi_rvalid && s_axi_rready |=>
		!s_axi_rvalid)
		else $error("read data not released");
endmodule // prcis_asserts

bind prcis_top prcis_asserts prcis_asserts_inst (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.dma_run, .ram_run, .periph_run, .sys_clk_src
);

/* File: test/prcis_top_tb.sv */
`timescale 1ns/1ps
module prcis_top_tb;
	import prcis_pkg::*;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_rready, dma_run, ram_run;
	logic        irq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, periph_run, clk_div, d;
	logic [3:0]  s_axi_wstrb, sys_clk_src;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	int          bad_count, n_compared, cyc;

	prcis_top prcis_top_inst (.*);

	always #50 aclk = !aclk;

	task automatic stop_test;
		if (bad_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Hang guard, well above the few hundred cycles the run needs
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			stop_test();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Ready lines stay high, so no release races between calls
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		output logic [1:0] rs);
		logic aw_d, w_d;
		aw_d = 1'b0;
		w_d = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			aw_d = aw_d | s_axi_awready;
			w_d = w_d | s_axi_wready;
			s_axi_awvalid <= !aw_d;
			s_axi_wvalid <= !w_d;
		end
		while (!(aw_d && w_d));
		do @(posedge aclk); while (!s_axi_bvalid);
		rs = s_axi_bresp;
		// Let registered outputs follow the write
		repeat (2) @(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v,
		output logic [1:0] rs);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		v = s_axi_rdata;
		rs = s_axi_rresp;
	endtask

	task automatic t_reset;
		chk("dma_run", 32'(dma_run), 32'h1);
		chk("ram_run", 32'(ram_run), 32'h1);
		chk("periph_run", periph_run, 32'h0);
		rd(ADDR_MSTP_X, d, r);
		chk("stop_x", d, MSTP_X_RST);
		rd(ADDR_MSTP_A, d, r);
		chk("stop_a", d, MSTP_A_RST);
		rd(ADDR_MSTP_C, d, r);
		chk("stop_c", d, MSTP_C_RST);
		chk("sys_clk_src", 32'(sys_clk_src), 32'(SRC_FAST));
	endtask

	task automatic t_stop;
		wr(ADDR_MSTP_A, 32'h1000_0000, r);
		chk("dma_run", 32'(dma_run), 32'h0);
		wr(ADDR_MSTP_C, 32'h0000_0001, r);
		chk("ram_run", 32'(ram_run), 32'h0);
		wr(ADDR_MSTP_X, 32'hFFFF_FF0F, r);
		chk("periph_run", periph_run, 32'h0000_00F0);
		wr(ADDR_MSTP_A, 32'h0, r);
		wr(ADDR_MSTP_C, 32'h0, r);
		chk("run_both", {30'h0, dma_run, ram_run}, 32'h3);
		rd(8'h30, d, r);
		chk("hole_rd", {d[31:2], r}, 32'h2);
		wr(8'h30, 32'hFFFF_FFFF, r);
		chk("hole_wr", 32'(r), 32'h2);
	endtask

	task automatic t_switch;
		logic [3:0] src [2] = '{SRC_SUB, SRC_PLL};
		// All masked: refused switches must not raise the line
		wr(ADDR_IRQ_MASK, 32'h0000_0000, r);
		wr(ADDR_IRQ_STAT, 32'h0000_003F, r);
		foreach (src[i])
		begin
			wr(ADDR_SYS_SEL, {28'h0, src[i]}, r);
			chk("sel_resp", 32'(r), 32'h2);
			chk("sys_clk_src", 32'(sys_clk_src), 32'(SRC_FAST));
		end
		chk("irq_masked", 32'(irq), 32'h0);
		wr(ADDR_IRQ_MASK, 32'h0000_0020, r);
		chk("irq_on", 32'(irq), 32'h1);
		wr(ADDR_IRQ_STAT, 32'h0000_0020, r);
		chk("irq_off", 32'(irq), 32'h0);
		do rd(ADDR_STABLE, d, r); while (d[OSC_FAST] !== 1'b1);
		wr(ADDR_STABLE, 32'h0, r);
		rd(ADDR_STABLE, d, r);
		chk("flag_ro", 32'(d[OSC_FAST]), 32'h1);
		wr(ADDR_MAIN_WAIT, 32'h0000_0014, r);
		wr(ADDR_OSC_CTRL, 32'h0000_0036, r);
		rd(ADDR_STABLE, d, r);
		chk("main_early", 32'(d[OSC_MAIN]), 32'h0);
		do rd(ADDR_STABLE, d, r); while (d[OSC_MAIN] !== 1'b1);
		wr(ADDR_DIV_CTRL, 32'h2182_1212, r);
		chk("clk_div", clk_div, 32'h2182_1212);
		wr(ADDR_SYS_SEL, {28'h0, SRC_MAIN}, r);
		chk("sys_clk_src", 32'(sys_clk_src), 32'(SRC_MAIN));
		wr(ADDR_SYS_SEL, {28'h0, SRC_FAST}, r);
		chk("sys_clk_src", 32'(sys_clk_src), 32'(SRC_FAST));
	endtask

	initial
	begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		{bad_count, n_compared, cyc} = '0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_stop();
		t_switch();
		stop_test();
	end
endmodule // prcis_top_tb
